/* File: hw/vac_top.sv */
// Output channel mapping, phase setting and picture level control for the video generator
//
// Behaviour
// - Split config: Y, chroma, composite on 1-3
// - All-composite config: same composite everywhere
// - Channel config applies only for composite format
// - GBR sync on green, or all three
// - Sync choice applies only for GBR format
// - Three channel enables; composite gates Y/B-Y/R-Y
// - Phase in whole degrees, -180 to +180
// - Increment past +180 gives -179
// - Decrement past -180 gives +179
// - Phase untouched by preset save and recall
// - Level mode off passes signal unchanged
// - High mode: white except last line per group
// - Low mode: black except last line per group
// - Level bounce alternates high and low per interval
// - Flat bounce alternates white and black fields
// - Interval 0.5 to 2.0 s in halves
// - Each channel drives two identical connectors
// - Factory recall restores documented default settings
`timescale 1ns/10ps
module vac_top #(
	parameter int HALF_SEC_CYC = vac_pkg::HALF_SEC_CYC
) (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	// Settings from the menu; a write is a preset or menu change
	input wire logic i_set_wr,
	input wire vac_pkg::vac_set_t i_set,
	input wire logic i_factory,
	input wire logic i_phase_up,
	input wire logic i_phase_dn,
	output vac_pkg::vac_set_t o_set,
	output vac_pkg::vac_ph_t o_phase,
	// Incoming sample stream
	input wire logic i_valid,
	input wire vac_pkg::vac_beat_t i_beat,
	output logic o_ready,
	// Outgoing stream, two connectors per channel
	output logic o_valid,
	input wire logic i_ready,
	output vac_pkg::vac_out_t o_conn_a,
	output vac_pkg::vac_out_t o_conn_b
);
	vac_pkg::vac_set_t pend;
	vac_pkg::vac_set_t cur;
	vac_pkg::vac_set_t eff;
	vac_pkg::vac_ph_t phase;
	logic [2:0] line_idx;
	logic [2:0] next_line_idx;
	logic bounce_tgl;
	logic bounce_cur;
	logic bounce_eff;
	logic [vac_pkg::TMR_W-1:0] tmr;
	logic [1:0] half_cnt;
	logic in_fire;
	vac_pkg::vac_out_t next_out;
	vac_pkg::vac_out_t skid;
	logic skid_vld;
	logic out_take;

	// Number of lines in one level group
	function automatic logic [2:0] grp_len(input logic pal);
		grp_len = pal ? vac_pkg::GRP_PAL : vac_pkg::GRP_NTSC;
	endfunction

	assign in_fire = i_ce && i_valid && o_ready;
	assign out_take = i_ce && o_valid && i_ready;

	// Pending settings, taken from the menu or the factory recall
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			pend <= vac_pkg::SET_FACTORY;
		end else if (i_ce) begin
			if (i_factory) begin
				pend <= vac_pkg::SET_FACTORY;
			end else if (i_set_wr) begin
				pend <= i_set;
			end
		end
	end

	// Applied settings only change on the first beat of a frame
	assign eff = (i_beat.sof) ? pend : cur;
	assign bounce_eff = (i_beat.sof) ? bounce_tgl : bounce_cur;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cur <= vac_pkg::SET_FACTORY;
			bounce_cur <= 1'b0;
		end else if (in_fire && i_beat.sof) begin
			cur <= pend;
			bounce_cur <= bounce_tgl;
		end
	end

	// Menu view of the pending settings, written in the same cycle as them
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_set <= vac_pkg::SET_FACTORY;
		end else if (i_ce) begin
			if (i_factory) begin
				o_set <= vac_pkg::SET_FACTORY;
			end else if (i_set_wr) begin
				o_set <= i_set;
			end
		end
	end

	// Phase setting; menu and preset writes leave it alone
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			phase <= vac_pkg::PH_ZERO;
		end else if (i_ce) begin
			if (i_factory) begin
				phase <= vac_pkg::PH_ZERO;
			end else if (i_phase_up && !i_phase_dn) begin
				if (phase == vac_pkg::PH_POS_MAX) begin
					phase <= vac_pkg::PH_NEG_WRAP;
				end else begin
					phase <= phase + 9'h001;
				end
			end else if (i_phase_dn && !i_phase_up) begin
				if (phase == vac_pkg::PH_NEG_MAX) begin
					phase <= vac_pkg::PH_POS_WRAP;
				end else begin
					phase <= phase - 9'h001;
				end
			end
		end
	end
	assign o_phase = phase;

	// Bounce interval timer, counted in half seconds
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			tmr <= '0;
			half_cnt <= 2'h0;
			bounce_tgl <= 1'b0;
		end else if (i_ce) begin
			if (tmr == vac_pkg::TMR_W'(HALF_SEC_CYC - 1)) begin
				tmr <= '0;
				if (half_cnt >= cur.period) begin
					half_cnt <= 2'h0;
					bounce_tgl <= ~bounce_tgl;
				end else begin
					half_cnt <= half_cnt + 2'h1;
				end
			end else begin
				tmr <= tmr + 1'b1;
			end
		end
	end

	// Active line position inside its group
	always_comb begin
		next_line_idx = line_idx;
		if (i_beat.sof) begin
			next_line_idx = 3'h0;
		end else if (i_beat.sol && i_beat.active) begin
			if (line_idx >= grp_len(i_beat.pal) - 3'h1) begin
				next_line_idx = 3'h0;
			end else begin
				next_line_idx = line_idx + 3'h1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			line_idx <= 3'h0;
		end else if (in_fire) begin
			line_idx <= next_line_idx;
		end
	end

	// Beat processing
	always_comb begin
		vac_pkg::vac_smp_t a;
		vac_pkg::vac_smp_t b;
		vac_pkg::vac_smp_t c;
		vac_pkg::vac_smp_t lvl;
		vac_pkg::vac_smp_t chroma;
		vac_pkg::vac_smp_t comp;
		logic last_line;
		logic flat;
		logic white;
		a = i_beat.a;
		b = i_beat.b;
		c = i_beat.c;
		lvl = vac_pkg::LVL_BLACK;
		last_line = (next_line_idx == grp_len(i_beat.pal) - 3'h1);
		flat = 1'b0;
		white = 1'b0;
		chroma = vac_pkg::LVL_BLANK;
		comp = vac_pkg::LVL_BLANK;
		unique case (eff.apl)
			vac_pkg::VAC_APL_OFF: begin
				flat = 1'b0;
			end
			vac_pkg::VAC_APL_HIGH: begin
				flat = !last_line;
				white = 1'b1;
			end
			vac_pkg::VAC_APL_LOW: begin
				flat = !last_line;
				white = 1'b0;
			end
			vac_pkg::VAC_APL_LVL_BOUNCE: begin
				flat = !last_line;
				white = !bounce_eff;
			end
			vac_pkg::VAC_APL_FLAT_BOUNCE: begin
				flat = 1'b1;
				white = !bounce_eff;
			end
			default: begin
				flat = 1'b0;
			end
		endcase
		if (white) begin
			lvl = vac_pkg::LVL_WHITE;
		end
		if (flat && i_beat.active) begin
			a = lvl;
			b = (i_beat.fmt == vac_pkg::VAC_FMT_GBR) ? lvl : vac_pkg::LVL_BLACK;
			c = b;
		end
		if (i_beat.fmt == vac_pkg::VAC_FMT_GBR && i_beat.sync) begin
			a = vac_pkg::LVL_SYNC_TIP;
			b = eff.sync_all ? vac_pkg::LVL_SYNC_TIP : vac_pkg::LVL_BLANK;
			c = b;
		end
		// Enables gate components before composite is formed
		a = eff.ch_en[0] ? a : vac_pkg::LVL_BLANK;
		b = eff.ch_en[1] ? b : vac_pkg::LVL_BLANK;
		c = eff.ch_en[2] ? c : vac_pkg::LVL_BLANK;
		chroma = vac_pkg::SMP_W'(b + c);
		comp = vac_pkg::SMP_W'(a + chroma);
		if (i_beat.fmt == vac_pkg::VAC_FMT_COMP) begin
			if (eff.cfg == vac_pkg::VAC_CFG_SPLIT) begin
				next_out = '{ch1: a, ch2: chroma, ch3: comp};
			end else begin
				next_out = '{ch1: comp, ch2: comp, ch3: comp};
			end
		end else begin
			next_out = '{ch1: a, ch2: b, ch3: c};
		end
	end

	// Two-entry output buffer: output register plus skid register
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_valid <= 1'b0;
			skid_vld <= 1'b0;
			o_ready <= 1'b1;
			skid <= '0;
			o_conn_a <= '0;
			o_conn_b <= '0;
		end else if (i_ce) begin
			if (!o_valid || i_ready) begin
				if (skid_vld) begin
					o_conn_a <= skid;
					o_conn_b <= skid;
					o_valid <= 1'b1;
					skid_vld <= in_fire;
					o_ready <= !in_fire;
					if (in_fire) begin
						skid <= next_out;
					end
				end else begin
					o_conn_a <= next_out;
					o_conn_b <= next_out;
					o_valid <= in_fire;
				end
			end else if (in_fire) begin
				skid <= next_out;
				skid_vld <= 1'b1;
				o_ready <= 1'b0;
			end
		end
	end

	// Checks
	sequence s_at_pos_max;
		i_ce && !i_factory && i_phase_up && !i_phase_dn && phase == vac_pkg::PH_POS_MAX;
	endsequence
	sequence s_at_neg_max;
		i_ce && !i_factory && i_phase_dn && !i_phase_up && phase == vac_pkg::PH_NEG_MAX;
	endsequence

	a_phase_wrap_up: assert property (@(posedge i_clk) disable iff (i_srst)
		s_at_pos_max |=> o_phase == vac_pkg::PH_NEG_WRAP)
		else $error("phase did not wrap to -179");
	a_phase_wrap_dn: assert property (@(posedge i_clk) disable iff (i_srst)
		s_at_neg_max |=> o_phase == vac_pkg::PH_POS_WRAP)
		else $error("phase did not wrap to +179");
	a_phase_in_range: assert property (@(posedge i_clk) disable iff (i_srst)
		o_phase >= vac_pkg::PH_NEG_MAX && o_phase <= vac_pkg::PH_POS_MAX)
		else $error("phase out of range");
	a_phase_preset_kept: assert property (@(posedge i_clk) disable iff (i_srst)
		i_ce && i_set_wr && !i_factory && !i_phase_up && !i_phase_dn |=> $stable(o_phase))
		else $error("preset write moved phase");
	a_factory_defaults: assert property (@(posedge i_clk) disable iff (i_srst)
		i_ce && i_factory |=> o_set == vac_pkg::SET_FACTORY && o_phase == vac_pkg::PH_ZERO)
		else $error("factory recall wrong");
	a_conn_pair_same: assert property (@(posedge i_clk) disable iff (i_srst)
		o_conn_a == o_conn_b)
		else $error("connector pair differs");
	a_cur_frame_only: assert property (@(posedge i_clk) disable iff (i_srst)
		!(in_fire && i_beat.sof) |=> $stable(cur))
		else $error("settings changed mid frame");
	a_allcomp_equal: assert property (@(posedge i_clk) disable iff (i_srst)
		in_fire && i_beat.fmt == vac_pkg::VAC_FMT_COMP && eff.cfg == vac_pkg::VAC_CFG_ALLCOMP
		|-> next_out.ch1 == next_out.ch2 && next_out.ch2 == next_out.ch3)
		else $error("composite channels differ");
	a_apl_off_pass: assert property (@(posedge i_clk) disable iff (i_srst)
		in_fire && eff.apl == vac_pkg::VAC_APL_OFF && i_beat.fmt == vac_pkg::VAC_FMT_YPBPR
		&& eff.ch_en == 3'h7 |-> next_out.ch1 == i_beat.a && next_out.ch3 == i_beat.c)
		else $error("level off altered signal");
	a_gbr_sync_green: assert property (@(posedge i_clk) disable iff (i_srst)
		in_fire && i_beat.fmt == vac_pkg::VAC_FMT_GBR && i_beat.sync && !eff.sync_all
		&& eff.ch_en == 3'h7 |-> next_out.ch1 == vac_pkg::LVL_SYNC_TIP
		&& next_out.ch2 == vac_pkg::LVL_BLANK)
		else $error("sync on green wrong");
	a_buffer_hold: assert property (@(posedge i_clk) disable iff (i_srst)
		i_ce && o_valid && !i_ready |=> o_valid && $stable(o_conn_a))
		else $error("stalled word lost");
	a_split_map: assert property (@(posedge i_clk) disable iff (i_srst)
		in_fire && i_beat.fmt == vac_pkg::VAC_FMT_COMP && eff.cfg == vac_pkg::VAC_CFG_SPLIT
		&& eff.apl == vac_pkg::VAC_APL_OFF && eff.ch_en == 3'h7
		|-> next_out.ch1 == i_beat.a
		&& next_out.ch2 == vac_pkg::SMP_W'(i_beat.b + i_beat.c)
		&& next_out.ch3 == vac_pkg::SMP_W'(i_beat.a + i_beat.b + i_beat.c))
		else $error("split channel mapping wrong");
	a_flat_bounce_lvl: assert property (@(posedge i_clk) disable iff (i_srst)
		in_fire && eff.apl == vac_pkg::VAC_APL_FLAT_BOUNCE && i_beat.active
		&& i_beat.fmt == vac_pkg::VAC_FMT_COMP && eff.ch_en == 3'h7
		|-> (next_out.ch1 == vac_pkg::LVL_WHITE || next_out.ch1 == vac_pkg::LVL_BLACK)
		&& next_out.ch1 == next_out.ch3)
		else $error("flat bounce level wrong");
	a_skid_refuse: assert property (@(posedge i_clk) disable iff (i_srst)
		i_ce && o_valid && !i_ready && in_fire |=> !o_ready)
		else $error("input not refused with buffer full");
endmodule

/* File: inc/vac_pkg.sv */
// Package with constants and types for the video output and level control block
package vac_pkg;
	// Sample and phase words
	localparam int SMP_W = 12;
	localparam int PH_W = 9;
	typedef logic signed [SMP_W-1:0] vac_smp_t;
	typedef logic signed [PH_W-1:0] vac_ph_t;

	// Signal levels on the sample scale
	localparam vac_smp_t LVL_BLACK = 12'h000;
	localparam vac_smp_t LVL_WHITE = 12'h2bc;
	localparam vac_smp_t LVL_SYNC_TIP = 12'hf1c;
	localparam vac_smp_t LVL_BLANK = 12'h000;

	// Subcarrier phase limits in degrees
	localparam vac_ph_t PH_ZERO = 9'h000;
	localparam vac_ph_t PH_POS_MAX = 9'h0b4;
	localparam vac_ph_t PH_NEG_MAX = 9'h14c;
	localparam vac_ph_t PH_POS_WRAP = 9'h0b3;
	localparam vac_ph_t PH_NEG_WRAP = 9'h14d;

	// Lines per level group
	localparam logic [2:0] GRP_NTSC = 3'h5;
	localparam logic [2:0] GRP_PAL = 3'h4;

	// Bounce timing
	localparam longint CLK_PERIOD_NS = 10;
	localparam longint HALF_SEC_NS = 500000000;
	localparam int HALF_SEC_CYC = int'(HALF_SEC_NS / CLK_PERIOD_NS);
	localparam int TMR_W = 32;

	typedef enum logic [1:0] {
		VAC_FMT_COMP = 2'b00,
		VAC_FMT_YPBPR = 2'b01,
		VAC_FMT_GBR = 2'b11
	} vac_fmt_t;

	typedef enum logic [2:0] {
		VAC_APL_OFF = 3'b000,
		VAC_APL_HIGH = 3'b001,
		VAC_APL_LOW = 3'b011,
		VAC_APL_LVL_BOUNCE = 3'b010,
		VAC_APL_FLAT_BOUNCE = 3'b110
	} vac_apl_t;

	typedef enum logic {
		VAC_CFG_SPLIT = 1'b0,
		VAC_CFG_ALLCOMP = 1'b1
	} vac_cfg_t;

	// Settings; period code n means (n+1) half seconds
	typedef struct packed {
		vac_cfg_t cfg;
		logic sync_all;
		logic [2:0] ch_en;
		vac_apl_t apl;
		logic [1:0] period;
	} vac_set_t;

	localparam vac_set_t SET_FACTORY = '{
		cfg: VAC_CFG_ALLCOMP,
		sync_all: 1'b1,
		ch_en: 3'h7,
		apl: VAC_APL_OFF,
		period: 2'h1
	};

	// One incoming sample beat; a/b/c hold Y,B-Y,R-Y for composite or the three components
	typedef struct packed {
		logic sof;
		logic sol;
		logic active;
		logic sync;
		logic pal;
		vac_fmt_t fmt;
		vac_smp_t a;
		vac_smp_t b;
		vac_smp_t c;
	} vac_beat_t;

	// One outgoing beat, one word per channel
	typedef struct packed {
		vac_smp_t ch1;
		vac_smp_t ch2;
		vac_smp_t ch3;
	} vac_out_t;
endpackage

/* File: tb/vac_sink.sv */
// Model of the video equipment under test: takes output words and may stall
`timescale 1ns/10ps
module vac_sink (
	// Clock and stall request
	input wire logic i_clk,
	input wire logic i_stall,
	// Stream from the block
	input wire logic i_valid,
	input wire vac_pkg::vac_out_t i_conn_a,
	input wire vac_pkg::vac_out_t i_conn_b,
	output logic o_ready
);
	vac_pkg::vac_out_t qa[$];
	vac_pkg::vac_out_t qb[$];
	initial o_ready = 1'b0;
	always @(posedge i_clk) begin
		if (i_valid && o_ready) begin
			qa.push_back(i_conn_a);
			qb.push_back(i_conn_b);
		end
		o_ready <= !i_stall;
	end
endmodule

/* File: tb/tb_top.sv */
// Testbench for the output mapping and picture level block
`timescale 1ns/10ps
module tb_top;
	localparam logic [11:0] A = 12'h100;
	localparam logic [11:0] B = 12'h020;
	localparam logic [11:0] C = 12'h010;
	localparam logic [11:0] W = vac_pkg::LVL_WHITE;
	localparam logic [11:0] T = vac_pkg::LVL_SYNC_TIP;
	logic clk;
	logic srst;
	logic set_wr;
	logic factory;
	logic up;
	logic dn;
	logic valid;
	logic stall;
	logic ready;
	logic o_valid;
	logic s_ready;
	vac_pkg::vac_set_t set;
	vac_pkg::vac_set_t o_set;
	vac_pkg::vac_ph_t phase;
	vac_pkg::vac_beat_t beat;
	vac_pkg::vac_out_t conn_a;
	vac_pkg::vac_out_t conn_b;
	vac_pkg::vac_beat_t bq[$];
	logic [35:0] f;
	int errors;
	int check_count;

	vac_top #(.HALF_SEC_CYC(20)) i_vac_top (.i_clk(clk), .i_srst(srst), .i_ce(1'b1),
		.i_set_wr(set_wr), .i_set(set), .i_factory(factory), .i_phase_up(up),
		.i_phase_dn(dn), .o_set(o_set), .o_phase(phase), .i_valid(valid), .i_beat(beat),
		.o_ready(ready), .o_valid(o_valid), .i_ready(s_ready), .o_conn_a(conn_a),
		.o_conn_b(conn_b));
	vac_sink i_vac_sink (.i_clk(clk), .i_stall(stall), .i_valid(o_valid), .i_conn_a(conn_a),
		.i_conn_b(conn_b), .o_ready(s_ready));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	function automatic vac_pkg::vac_beat_t mk(input logic [4:0] fl, input logic [11:0] a);
		return vac_pkg::vac_beat_t'({fl, vac_pkg::VAC_FMT_COMP, a, B, C});
	endfunction

	// Next word taken by the sink; unknown if none or the connectors differ
	function automatic logic [35:0] nxt;
		vac_pkg::vac_out_t b;
		if (i_vac_sink.qa.size() == 0) return 'x;
		b = i_vac_sink.qb.pop_front();
		nxt = i_vac_sink.qa.pop_front();
		if (b !== nxt) nxt = 'x;
	endfunction

	task automatic put(input logic [9:0] s);
		set_wr <= 1'b1;
		set <= vac_pkg::vac_set_t'(s);
		@(posedge clk);
		set_wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic run;
		foreach (bq[i]) begin
			valid <= 1'b1;
			beat <= bq[i];
			do @(posedge clk); while (!ready);
		end
		valid <= 1'b0;
		repeat (40) if (i_vac_sink.qa.size() < bq.size()) @(posedge clk);
	endtask

	task automatic step(input int n, input logic dir);
		repeat (n) begin
			up <= dir;
			dn <= !dir;
			@(posedge clk);
		end
		up <= 1'b0;
		dn <= 1'b0;
		@(posedge clk);
	endtask

	task automatic t_phase;
		check(o_set, vac_pkg::SET_FACTORY);
		step(180, 1'b1);
		check(phase, vac_pkg::PH_POS_MAX);
		step(1, 1'b1);
		check(phase, vac_pkg::PH_NEG_WRAP);
		step(1, 1'b0);
		check(phase, vac_pkg::PH_NEG_MAX);
		step(1, 1'b0);
		check(phase, vac_pkg::PH_POS_WRAP);
		put(10'h0);
		check(phase, vac_pkg::PH_POS_WRAP);
		factory <= 1'b1;
		@(posedge clk);
		factory <= 1'b0;
		@(posedge clk);
		check(phase, vac_pkg::PH_ZERO);
		check(o_set, vac_pkg::SET_FACTORY);
	endtask

	task automatic t_map;
		bq = '{mk(5'b11100, A)};
		run;
		check(nxt(), {3{A + B + C}});
		put({1'b0, 1'b1, 3'h7, vac_pkg::VAC_APL_OFF, 2'h0});
		run;
		check(nxt(), {A, B + C, A + B + C});
		put({1'b0, 1'b1, 3'h6, vac_pkg::VAC_APL_OFF, 2'h0});
		run;
		check(nxt(), {12'h0, B + C, B + C});
		bq = '{vac_pkg::vac_beat_t'({5'b11100, vac_pkg::VAC_FMT_YPBPR, A, B, C})};
		run;
		check(nxt(), {12'h0, B, C});
		put({1'b1, 1'b0, 3'h7, vac_pkg::VAC_APL_OFF, 2'h0});
		bq = '{vac_pkg::vac_beat_t'({5'b10010, vac_pkg::VAC_FMT_GBR, A, B, C}),
			vac_pkg::vac_beat_t'({5'b10010, vac_pkg::VAC_FMT_YPBPR, T, T, T})};
		run;
		check(nxt(), {T, 24'h0});
		check(nxt(), {3{T}});
		put({1'b1, 1'b1, 3'h7, vac_pkg::VAC_APL_OFF, 2'h0});
		bq = '{bq[0]};
		run;
		check(nxt(), {3{T}});
	endtask

	task automatic t_apl(input logic [2:0] mode, input logic pal, input logic [11:0] lvl);
		put({1'b1, 1'b1, 3'h7, mode, 2'h0});
		bq = '{mk({4'b1110, pal}, A)};
		repeat (pal ? 3 : 4) bq.push_back(mk({4'b0110, pal}, A));
		run;
		foreach (bq[i]) check(nxt(), i < bq.size() - 1 ? {3{lvl}} : {3{A + B + C}});
	endtask

	task automatic t_bounce(input logic [2:0] mode, input logic [1:0] per);
		put({1'b1, 1'b1, 3'h7, mode, per});
		valid <= 1'b1;
		beat <= mk(5'b11100, A);
		@(posedge clk);
		valid <= 1'b0;
		// Frames one interval apart, so exactly one toggle lies between them
		repeat (20 * (per + 1) - 1) @(posedge clk);
		valid <= 1'b1;
		@(posedge clk);
		valid <= 1'b0;
		repeat (4) @(posedge clk);
		f = nxt();
		check(f === {3{W}} || f === 36'h0, 36'h1);
		check(nxt(), f === {3{W}} ? 36'h0 : {3{W}});
	endtask

	task automatic t_skid;
		put({1'b1, 1'b1, 3'h7, vac_pkg::VAC_APL_OFF, 2'h0});
		stall <= 1'b1;
		bq = '{mk(5'b11100, A), mk(5'b01100, B), mk(5'b01100, C)};
		fork
			run;
			begin
				repeat (8) @(posedge clk);
				check(ready, 36'h0);
				stall <= 1'b0;
			end
		join
		foreach (bq[i]) check(nxt(), {3{bq[i].a + B + C}});
	endtask

	initial begin
		{srst, set_wr, factory, up, dn, valid, stall} = 7'h40;
		set = '0;
		beat = '0;
		errors = 0;
		check_count = 0;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_phase;
		t_map;
		t_apl(vac_pkg::VAC_APL_HIGH, 1'b0, W);
		t_apl(vac_pkg::VAC_APL_LOW, 1'b1, 12'h0);
		t_bounce(vac_pkg::VAC_APL_FLAT_BOUNCE, 2'h0);
		t_bounce(vac_pkg::VAC_APL_LVL_BOUNCE, 2'h1);
		t_skid;
		print_verdict;
	end

	initial begin
		#100us;
		errors++;
		print_verdict;
	end
endmodule
